// [core/mps_defs.svh]
// Timing constants for the module power mode sequencer.
// Assumes a 25 MHz system clock; included by the core only.
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH
`define MPS_CLK_HZ 25000000
`define MPS_PWR_ON_MS 500
`define MPS_RESET_MS 50
`define MPS_WAKE_MS 30
// Scale per millisecond first; ms times Hz would overflow 32 bits
`define MPS_CYC_PER_MS (`MPS_CLK_HZ / 1000)
`define MPS_PWR_ON_CYC (`MPS_PWR_ON_MS * `MPS_CYC_PER_MS)
`define MPS_RESET_CYC (`MPS_RESET_MS * `MPS_CYC_PER_MS)
`define MPS_WAKE_CYC (`MPS_WAKE_MS * `MPS_CYC_PER_MS)
`define MPS_CNT_W 24
`define MPS_TMR_W 32
`endif

// [core/mps_pkg.sv]
// Types for the module power mode sequencer.
// Assumes nothing beyond the defs header.
package mps_pkg;
  typedef enum logic [2:0] {
    MPS_OFF = 3'h0,
    MPS_IDLE = 3'h1,
    MPS_ACTIVE = 3'h2,
    MPS_SLEEP = 3'h3
  } mps_state_t;
endpackage : mps_pkg

// [core/mps_sequencer.sv]
// Power mode sequencer: off, active, idle and deep sleep.
// Assumes host pins are synchronous to clk_i; network stack gives events.
// Operation
// - Active state: awake, all functions usable, data sent and received.
// - Idle state: pending, still receives paging messages.
// - Deep sleep keeps only the real-time clock, network disconnected.
// - Attach or tracking area update carries a deep sleep request.
// - Reachable timer loaded from network; expiry enters deep sleep.
// - No deep sleep request while connected or during emergency setup.
// - Deep sleep halts all networking activity.
// - Periodic update timer keeps running in deep sleep.
// - Periodic update timer expiry leaves deep sleep.
// - Wake pin or power enable low wakes from deep sleep.
// - Power enable low 500 ms from off powers the device on.
// - Reset pin low 50 ms resets the device.
// - Wake pin low 30 ms wakes from deep sleep.
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_sequencer #(
  // Hold counts in clock cycles; each must be at least 1
  parameter int unsigned PWR_ON_CYC = `MPS_PWR_ON_CYC, // Power enable hold
  parameter int unsigned RESET_CYC = `MPS_RESET_CYC, // Reset pin hold
  parameter int unsigned WAKE_CYC = `MPS_WAKE_CYC // Wake pin hold
) (
  input wire logic clk_i, // 25 MHz clock
  input wire logic sys_rst_i, // Sync reset, high
  input wire logic power_enable_n_i, // Power enable pin, low
  input wire logic reset_n_i, // Reset pin, low
  input wire logic wake_n_i, // Wake pin, low
  input wire logic connected_i, // Network connection level
  input wire logic emergency_pdn_i, // Emergency setup in progress
  input wire logic attach_i, // Attach or area update pulse
  input wire logic reach_load_i, // Load strobe for reachable value from network
  input wire logic [`MPS_TMR_W-1:0] reach_val_i, // Reachable ticks
  input wire logic [`MPS_TMR_W-1:0] periodic_val_i, // Periodic ticks
  input wire logic rtc_tick_i, // Real-time clock tick
  output mps_pkg::mps_state_t state_o, // Current mode
  output logic sleep_req_o, // Deep sleep request in message
  output logic net_en_o, // Networking allowed
  output logic rtc_en_o, // Real-time clock running
  output logic dev_reset_o // Internal reset pulse
);
  import mps_pkg::*;

  mps_state_t state;
  logic [`MPS_CNT_W-1:0] pe_cnt, rst_cnt, wk_cnt;
  logic [`MPS_TMR_W-1:0] reach_tmr, periodic_tmr;
  logic reach_run, pe_hit, rst_hit, wk_hit;

  localparam logic [`MPS_CNT_W-1:0] PE_CYC = `MPS_CNT_W'(PWR_ON_CYC);
  localparam logic [`MPS_CNT_W-1:0] RST_CYC = `MPS_CNT_W'(RESET_CYC);
  localparam logic [`MPS_CNT_W-1:0] WK_CYC = `MPS_CNT_W'(WAKE_CYC);

  // Low-time filters; counters saturate so a long hold fires once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || power_enable_n_i) begin
      pe_cnt <= '0;
    end else if (pe_cnt != PE_CYC) begin
      pe_cnt <= pe_cnt + `MPS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || reset_n_i) begin
      rst_cnt <= '0;
    end else if (rst_cnt != RST_CYC) begin
      rst_cnt <= rst_cnt + `MPS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || wake_n_i) begin
      wk_cnt <= '0;
    end else if (wk_cnt != WK_CYC) begin
      wk_cnt <= wk_cnt + `MPS_CNT_W'(1);
    end
  end

  // Hit on the single cycle the count sits one below its threshold
  assign pe_hit = !power_enable_n_i && (pe_cnt == PE_CYC - `MPS_CNT_W'(1));
  assign rst_hit = !reset_n_i && (rst_cnt == RST_CYC - `MPS_CNT_W'(1));
  assign wk_hit = !wake_n_i && (wk_cnt == WK_CYC - `MPS_CNT_W'(1));

  // Reachable timer counts real-time ticks while awake
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || rst_hit || state == MPS_OFF || state == MPS_SLEEP) begin
      reach_run <= 1'b0;
      reach_tmr <= '0;
    end else if (reach_load_i) begin
      reach_run <= 1'b1;
      reach_tmr <= reach_val_i;
    end else if (connected_i) begin
      reach_run <= 1'b0; // Traffic cancels the reachable window
    end else if (reach_run && rtc_tick_i && reach_tmr != '0) begin
      reach_tmr <= reach_tmr - `MPS_TMR_W'(1);
    end
  end

  // Periodic update timer, reloaded on each entry to deep sleep
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || rst_hit) begin
      periodic_tmr <= '0;
    end else if (state != MPS_SLEEP) begin
      periodic_tmr <= periodic_val_i;
    end else if (rtc_tick_i && periodic_tmr != '0) begin
      periodic_tmr <= periodic_tmr - `MPS_TMR_W'(1);
    end
  end

  // Mode sequencing; reset returns to the power-on landing state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= MPS_OFF;
    end else if (rst_hit && state != MPS_OFF) begin
      state <= MPS_ACTIVE;
    end else begin
      case (state)
        MPS_OFF: begin
          if (pe_hit) begin
            state <= MPS_ACTIVE;
          end
        end
        MPS_ACTIVE: begin
          if (!connected_i) begin
            state <= MPS_IDLE;
          end
        end
        MPS_IDLE: begin
          if (connected_i) begin
            state <= MPS_ACTIVE;
          end else if (reach_run && reach_tmr == '0) begin
            state <= MPS_SLEEP;
          end
        end
        MPS_SLEEP: begin
          if (wk_hit || pe_hit) begin
            state <= MPS_ACTIVE;
          end else if (periodic_tmr == '0) begin
            state <= MPS_ACTIVE;
          end
        end
        default: state <= MPS_OFF;
      endcase
    end
  end

  // Request flag registered from the attach pulse
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sleep_req_o <= 1'b0;
    end else begin
      sleep_req_o <= attach_i && !connected_i && !emergency_pdn_i
                     && (state == MPS_ACTIVE || state == MPS_IDLE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dev_reset_o <= 1'b0;
    end else begin
      dev_reset_o <= rst_hit && state != MPS_OFF;
    end
  end

  assign state_o = state;
  assign net_en_o = (state == MPS_ACTIVE) || (state == MPS_IDLE);
  assign rtc_en_o = (state != MPS_OFF);

  // Two-cycle mode patterns shared by the checks below
  sequence off_to_active;
    state == MPS_OFF ##1 state == MPS_ACTIVE;
  endsequence

  sequence wake_rise;
    state == MPS_SLEEP ##1 state == MPS_ACTIVE;
  endsequence

  sequence idle_to_sleep;
    state == MPS_IDLE ##1 state == MPS_SLEEP;
  endsequence

  sequence sleep_stays;
    state == MPS_SLEEP ##1 state == MPS_SLEEP;
  endsequence

  power_on_gate_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    off_to_active |-> $past(pe_cnt) == PE_CYC - `MPS_CNT_W'(1))
    else $error("power on without full enable hold");
  short_pulse_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == MPS_OFF && power_enable_n_i |=> state == MPS_OFF)
    else $error("power on from a released pin");
  wake_filter_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == MPS_SLEEP && wake_n_i && power_enable_n_i && !rst_hit
    && periodic_tmr != '0 |=> state == MPS_SLEEP)
    else $error("deep sleep left with pins released");
  reset_pulse_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    dev_reset_o |-> state == MPS_ACTIVE
    && $past(rst_cnt) == RST_CYC - `MPS_CNT_W'(1))
    else $error("reset pulse without full reset hold");
  reset_return_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    rst_hit && state != MPS_OFF |=> state == MPS_ACTIVE)
    else $error("reset did not land in active");
  sleep_net_off_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state == MPS_SLEEP |-> !net_en_o && rtc_en_o)
    else $error("network active in deep sleep");
  wake_cause_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    wake_rise |-> $past(wk_hit) || $past(pe_hit)
    || $past(periodic_tmr) == '0 || $past(rst_hit))
    else $error("deep sleep left without cause");
  sleep_entry_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    idle_to_sleep |-> $past(reach_run) && $past(reach_tmr) == '0)
    else $error("deep sleep before reachable expiry");
  no_req_conn_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    connected_i || emergency_pdn_i |=> !sleep_req_o)
    else $error("sleep requested while barred");
  periodic_run_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    sleep_stays ##0 ($past(rtc_tick_i) && $past(periodic_tmr) != '0)
    |-> periodic_tmr == $past(periodic_tmr) - `MPS_TMR_W'(1))
    else $error("periodic timer stalled in deep sleep");
endmodule : mps_sequencer

// [test/mps_host.sv]
// Host model that drives the active-low control pins of the sequencer.
// Assumes holds are counted in falling edges of the system clock.
`timescale 1ns/1ps
module mps_host (
  input wire logic clk_i, // System clock
  output logic power_enable_n_o, // Power enable pin
  output logic reset_n_o, // Reset pin
  output logic wake_n_o // Wake pin
);
  initial begin
    {power_enable_n_o, reset_n_o, wake_n_o} = 3'h7;
  end
  // Pin 0 power, 1 reset, 2 wake; released pins return to the pull-up
  task automatic hold_low(input int pin, input int n);
    @(negedge clk_i);
    case (pin)
      0: power_enable_n_o = 1'b0;
      1: reset_n_o = 1'b0;
      default: wake_n_o = 1'b0;
    endcase
    repeat (n) @(negedge clk_i);
    {power_enable_n_o, reset_n_o, wake_n_o} = 3'h7;
  endtask : hold_low
endmodule : mps_host

// [test/test_module_power_mode_sequencer.sv]
// Self-checking bench for the power mode sequencer.
// Assumes the core takes its hold counts as parameters.
`timescale 1ns/1ps
module test_module_power_mode_sequencer;
  import mps_pkg::*;
  logic clk_i, sys_rst_i, pen_n, rst_n, wake_n, connected_i, emergency_pdn_i;
  logic attach_i, reach_load_i, rtc_tick_i;
  logic [31:0] reach_val_i, periodic_val_i;
  mps_state_t state_o;
  logic sleep_req_o, net_en_o, rtc_en_o, dev_reset_o;
  int n_mismatch = 0;
  int cmp_count = 0;
  // One clock per millisecond of hold keeps the run short
  localparam int unsigned PE_N = 500;
  localparam int unsigned RST_N = 50;
  localparam int unsigned WK_N = 30;
  mps_host u_host (.clk_i(clk_i), .power_enable_n_o(pen_n),
    .reset_n_o(rst_n), .wake_n_o(wake_n));
  mps_sequencer #(.PWR_ON_CYC(PE_N), .RESET_CYC(RST_N), .WAKE_CYC(WK_N))
    u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .power_enable_n_i(pen_n), .reset_n_i(rst_n), .wake_n_i(wake_n),
    .connected_i(connected_i), .emergency_pdn_i(emergency_pdn_i),
    .attach_i(attach_i), .reach_load_i(reach_load_i),
    .reach_val_i(reach_val_i), .periodic_val_i(periodic_val_i),
    .rtc_tick_i(rtc_tick_i), .state_o(state_o), .sleep_req_o(sleep_req_o),
    .net_en_o(net_en_o), .rtc_en_o(rtc_en_o), .dev_reset_o(dev_reset_o));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_st(input mps_state_t s);
    int k;
    k = 0;
    while (state_o !== s && k < 20) begin
      @(negedge clk_i);
      k++;
    end
    chk(32'(state_o), 32'(s));
  endtask : wait_st
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_i);
      rtc_tick_i = 1'b1;
      @(negedge clk_i);
      rtc_tick_i = 1'b0;
    end
  endtask : tick
  task automatic att(input logic exp);
    @(negedge clk_i);
    attach_i = 1'b1;
    @(negedge clk_i);
    chk(32'(sleep_req_o), 32'(exp));
    attach_i = 1'b0;
  endtask : att
  // Idle, reachable value of 3 ticks, then expiry
  task automatic to_sleep;
    wait_st(MPS_IDLE);
    @(negedge clk_i);
    reach_val_i = 32'h3;
    reach_load_i = 1'b1;
    @(negedge clk_i);
    reach_load_i = 1'b0;
    tick(3);
    wait_st(MPS_SLEEP);
  endtask : to_sleep
  task automatic t_power;
    u_host.hold_low(0, PE_N - 1);
    repeat (3) @(negedge clk_i);
    chk(32'(state_o), 32'(MPS_OFF));
    chk(32'({net_en_o, rtc_en_o}), 32'h0);
    u_host.hold_low(0, PE_N);
    chk(32'(state_o), 32'(MPS_ACTIVE));
    chk(32'(net_en_o), 32'h1);
  endtask : t_power
  task automatic t_request;
    connected_i = 1'b1;
    att(1'b0);
    connected_i = 1'b0;
    emergency_pdn_i = 1'b1;
    att(1'b0);
    emergency_pdn_i = 1'b0;
    att(1'b1);
  endtask : t_request
  task automatic t_sleep;
    periodic_val_i = 32'h2;
    to_sleep();
    chk(32'({net_en_o, rtc_en_o}), 32'h1);
    tick(2);
    wait_st(MPS_ACTIVE);
  endtask : t_sleep
  task automatic t_wake;
    periodic_val_i = 32'h3E8;
    to_sleep();
    u_host.hold_low(2, WK_N - 1);
    chk(32'(state_o), 32'(MPS_SLEEP));
    u_host.hold_low(2, WK_N);
    chk(32'(state_o), 32'(MPS_ACTIVE));
    to_sleep();
    u_host.hold_low(0, PE_N);
    wait_st(MPS_ACTIVE);
  endtask : t_wake
  task automatic t_reset;
    to_sleep();
    u_host.hold_low(1, RST_N - 1);
    chk(32'(state_o), 32'(MPS_SLEEP));
    u_host.hold_low(1, RST_N);
    chk(32'(state_o), 32'(MPS_ACTIVE));
    chk(32'(dev_reset_o), 32'h1);
    @(negedge clk_i);
    chk(32'(dev_reset_o), 32'h0);
  endtask : t_reset
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Roughly four times the longest expected run
  initial begin
    repeat (8000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {sys_rst_i, connected_i, emergency_pdn_i} = 3'h4;
    {attach_i, reach_load_i, rtc_tick_i} = 3'h0;
    reach_val_i = 32'h0;
    periodic_val_i = 32'h0;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_power();
    t_request();
    t_sleep();
    t_wake();
    t_reset();
    tally_and_finish();
  end
endmodule : test_module_power_mode_sequencer
